// ==== pkg/irq_pkg.sv ====
// Shared constants for the interrupt status, mask and pin output block.
package irq_pkg;

    // Register port geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int BYTE_CNT_W = 8;

    // Register addresses on the register port.
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_PIN_CFG = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_THRESH = 8'h06;
    localparam logic [ADDR_W-1:0] OFS_PIN_B_FUNC = 8'h0B;

    // Status register fields.
    localparam int ST_CNT_LSB = 8;
    localparam int ST_FIFO_CLR_BIT = 15;
    localparam int ST_SPARE_HI_BIT = 7;
    localparam int ST_SLOT_B_BIT = 6;
    localparam int ST_SLOT_A_BIT = 5;
    localparam int ST_SPARE_LO_W = 5;
    localparam int FLAG_W = 8;
    localparam logic [ST_SPARE_LO_W-1:0] SPARE_LO_CLR_KEY = 5'h1F;
    localparam int SPARE_EVT_W = 6;

    // Mask register fields and reset value.
    localparam int MSK_FIFO_BIT = 8;
    localparam int MSK_SLOT_B_BIT = 6;
    localparam int MSK_SLOT_A_BIT = 5;
    localparam logic [DATA_W-1:0] MASK_RST = 16'h01FF;

    // Pin configuration register fields and reset value.
    localparam int PC_B_DRIVE_BIT = 9;
    localparam int PC_B_POL_BIT = 8;
    localparam int PC_A_ENA_BIT = 2;
    localparam int PC_A_DRIVE_BIT = 1;
    localparam int PC_A_POL_BIT = 0;
    localparam logic [DATA_W-1:0] PIN_CFG_RST = 16'h0000;

    // Threshold register field and reset value.
    localparam int TH_LSB = 8;
    localparam int TH_W = 6;
    localparam logic [DATA_W-1:0] THRESH_RST = 16'h0000;

    // Pin B function select field, reset value and interrupt code.
    localparam int FS_LSB = 8;
    localparam int FS_W = 5;
    localparam logic [FS_W-1:0] FS_IRQ_CODE = 5'h01;
    localparam logic [DATA_W-1:0] PIN_B_FUNC_RST = 16'h0000;

endpackage

// ==== pkg/pin_cfg_if.sv ====
// Interface carrying one interrupt pin's level and configuration.
`timescale 1ns/1ps
`default_nettype none
interface pin_cfg_if;
    logic irq;
    logic enable;
    logic drive_mode;
    logic polarity;

    // The controller drives the settings, the pin driver consumes them.
    modport ctrl (output irq, output enable, output drive_mode,
        output polarity);
    modport drv (input irq, input enable, input drive_mode,
        input polarity);
endinterface
`default_nettype wire

// ==== design/sticky_flags.sv ====
// Bank of sticky event flags, set by hardware and cleared by software.
`timescale 1ns/1ps
`default_nettype none
module sticky_flags
    import irq_pkg::*;
#(
    parameter int W = FLAG_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] flags_q
);
    logic [W-1:0] flags_d;

    // Each flag holds until cleared; a set in the clear cycle wins.
    always_comb begin
        flags_d = flags_q;
        for (int i = 0; i < W; i++) begin
            if (en) begin
                flags_d[i] = set[i] | (flags_q[i] & ~clr[i]);
            end
        end
    end

    // Flag storage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end
endmodule
`default_nettype wire

// ==== design/pin_driver.sv ====
// Output stage of one interrupt pin: polarity, drive mode and enable.
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    pin_cfg_if.drv cfg,
    output logic pin_o,
    output logic pin_oe
);
    logic pin_d;
    logic oe_d;

    // Level follows polarity; drive mode decides when the pin is driven.
    always_comb begin
        pin_d = pin_o;
        oe_d = pin_oe;
        if (en) begin
            pin_d = cfg.irq ^ cfg.polarity;
            oe_d = cfg.enable & (~cfg.drive_mode | cfg.irq);
        end
    end

    // Registered pin outputs; the pin floats during reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_o <= pin_d;
            pin_oe <= oe_d;
        end
    end
endmodule
`default_nettype wire

// ==== design/irq_status_mask_pin_logic.sv ====
// Interrupt status, masking and interrupt pin control of the front end.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module irq_status_mask_pin_logic
    import irq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [BYTE_CNT_W-1:0] queue_byte_count,
    output logic queue_flush,
    input wire logic first_slot_event,
    input wire logic second_slot_event,
    input wire logic [SPARE_EVT_W-1:0] spare_event,
    output logic irq_pin_a_o,
    output logic irq_pin_a_oe,
    output logic irq_pin_b_o,
    output logic irq_pin_b_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // True when a write strobe targets the given register address.
    function automatic logic wr_hit(input logic wr,
            input logic [ADDR_W-1:0] addr,
            input logic [ADDR_W-1:0] target);
        wr_hit = wr && (addr == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [DATA_W-1:0] mask_q;
    logic [DATA_W-1:0] mask_d;
    logic [DATA_W-1:0] pin_cfg_q;
    logic [DATA_W-1:0] pin_cfg_d;
    logic [DATA_W-1:0] thresh_q;
    logic [DATA_W-1:0] thresh_d;
    logic [DATA_W-1:0] pin_b_func_q;
    logic [DATA_W-1:0] pin_b_func_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic flush_q;
    logic flush_d;
    logic irq_q;
    logic irq_d;
    logic pin_a_irq_q;
    logic pin_a_irq_d;
    logic pin_b_irq_q;
    logic pin_b_irq_d;

    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] flag_clr;
    logic [FLAG_W-1:0] flags;
    logic wr_status;
    logic [BYTE_CNT_W-2:0] queue_words;
    logic [TH_W-1:0] queue_word_threshold;
    logic queue_over_threshold;
    logic first_slot_flag;
    logic second_slot_flag;
    logic first_slot_irq_block;
    logic second_slot_irq_block;
    logic queue_irq_block;
    logic pin_a_enable;
    logic pin_a_drive_mode;
    logic pin_a_polarity;
    logic pin_b_drive_mode;
    logic pin_b_polarity;
    logic [FS_W-1:0] pin_b_function_select;

    pin_cfg_if pin_a_cfg ();
    pin_cfg_if pin_b_cfg ();

    ////////////////////////////////////////////////////////////////////////
    // Field views of the configuration registers.

    // Mask bits; a 1 blocks the source.
    assign queue_irq_block = mask_q[MSK_FIFO_BIT];
    assign second_slot_irq_block = mask_q[MSK_SLOT_B_BIT];
    assign first_slot_irq_block = mask_q[MSK_SLOT_A_BIT];

    // Pin configuration bits for both interrupt pins.
    assign pin_b_drive_mode = pin_cfg_q[PC_B_DRIVE_BIT];
    assign pin_b_polarity = pin_cfg_q[PC_B_POL_BIT];
    assign pin_a_enable = pin_cfg_q[PC_A_ENA_BIT];
    assign pin_a_drive_mode = pin_cfg_q[PC_A_DRIVE_BIT];
    assign pin_a_polarity = pin_cfg_q[PC_A_POL_BIT];

    // Threshold and pin B function fields.
    assign queue_word_threshold = thresh_q[TH_LSB +: TH_W];
    assign pin_b_function_select = pin_b_func_q[FS_LSB +: FS_W];

    ////////////////////////////////////////////////////////////////////////
    // Sticky status flags.

    assign wr_status = wr_hit(reg_wr, reg_addr, OFS_STATUS);

    // Hardware events that set each status flag.
    always_comb begin
        flag_set = '0;
        flag_set[ST_SLOT_B_BIT] = second_slot_event;
        flag_set[ST_SLOT_A_BIT] = first_slot_event;
        flag_set[ST_SPARE_HI_BIT] = spare_event[ST_SPARE_LO_W];
        flag_set[ST_SPARE_LO_W-1:0] = spare_event[ST_SPARE_LO_W-1:0];
    end

    // Write-one clears bits 7, 6 and 5; a zero bit leaves its flag alone.
    always_comb begin
        flag_clr = '0;
        if (wr_status) begin
            flag_clr[ST_SLOT_B_BIT] = reg_wdata[ST_SLOT_B_BIT];
            flag_clr[ST_SLOT_A_BIT] = reg_wdata[ST_SLOT_A_BIT];
            flag_clr[ST_SPARE_HI_BIT] = reg_wdata[ST_SPARE_HI_BIT];
            // The low spare field clears only on the all-ones key.
            if (reg_wdata[ST_SPARE_LO_W-1:0] == SPARE_LO_CLR_KEY) begin
                flag_clr[ST_SPARE_LO_W-1:0] = '1;
            end
        end
    end

    // The flag bank never looks at the pin enable, so it keeps running.
    sticky_flags #(
        .W(FLAG_W)
    ) u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .en(en),
        .set(flag_set),
        .clr(flag_clr),
        .flags_q(flags)
    );

    assign second_slot_flag = flags[ST_SLOT_B_BIT];
    assign first_slot_flag = flags[ST_SLOT_A_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    // Next values of the writable registers.
    always_comb begin
        mask_d = mask_q;
        pin_cfg_d = pin_cfg_q;
        thresh_d = thresh_q;
        pin_b_func_d = pin_b_func_q;
        if (en) begin
            if (wr_hit(reg_wr, reg_addr, OFS_MASK)) begin
                mask_d = reg_wdata;
            end else if (wr_hit(reg_wr, reg_addr, OFS_PIN_CFG)) begin
                pin_cfg_d = reg_wdata;
            end else if (wr_hit(reg_wr, reg_addr, OFS_THRESH)) begin
                thresh_d = reg_wdata;
            end else if (wr_hit(reg_wr, reg_addr, OFS_PIN_B_FUNC)) begin
                pin_b_func_d = reg_wdata;
            end
        end
    end

    // Register storage; all masks come out of reset blocking.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= MASK_RST;
            pin_cfg_q <= PIN_CFG_RST;
            thresh_q <= THRESH_RST;
            pin_b_func_q <= PIN_B_FUNC_RST;
        end else begin
            mask_q <= mask_d;
            pin_cfg_q <= pin_cfg_d;
            thresh_q <= thresh_d;
            pin_b_func_q <= pin_b_func_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Queue flush command.

    // A one in status bit 15 emits a single flush pulse to the queue.
    always_comb begin
        flush_d = flush_q;
        if (en) begin
            flush_d = wr_status && reg_wdata[ST_FIFO_CLR_BIT];
        end
    end

    // Flush pulse storage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= flush_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads.

    // Read data is registered; unmapped addresses read as zero.
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = rvalid_q;
        if (en) begin
            rvalid_d = reg_rd;
            if (!reg_rd) begin
                rdata_d = rdata_q;
            end else if (reg_addr == OFS_STATUS) begin
                rdata_d = {queue_byte_count, flags};
            end else if (reg_addr == OFS_MASK) begin
                rdata_d = mask_q;
            end else if (reg_addr == OFS_PIN_CFG) begin
                rdata_d = pin_cfg_q;
            end else if (reg_addr == OFS_THRESH) begin
                rdata_d = thresh_q;
            end else if (reg_addr == OFS_PIN_B_FUNC) begin
                rdata_d = pin_b_func_q;
            end else begin
                rdata_d = '0;
            end
        end
    end

    // Read answer storage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt combining.

    // The count is in bytes, the threshold in two-byte words.
    assign queue_words = queue_byte_count[BYTE_CNT_W-1:1];
    assign queue_over_threshold =
        (queue_words > {1'b0, queue_word_threshold});

    // An unmasked slot A flag, slot B flag or queue over threshold raises the interrupt level; spare flags never do.
    always_comb begin
        irq_d = irq_q;
        pin_a_irq_d = pin_a_irq_q;
        pin_b_irq_d = pin_b_irq_q;
        if (en) begin
            irq_d = (first_slot_flag & ~first_slot_irq_block)
                | (second_slot_flag & ~second_slot_irq_block)
                | (queue_over_threshold & ~queue_irq_block);
            pin_a_irq_d = irq_d;
            pin_b_irq_d = irq_d;
        end
    end

    // Interrupt level storage, one copy per pin stage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            pin_a_irq_q <= 1'b0;
            pin_b_irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
            pin_a_irq_q <= pin_a_irq_d;
            pin_b_irq_q <= pin_b_irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pins.

    // Pin A settings; a cleared enable floats the pin.
    assign pin_a_cfg.irq = pin_a_irq_q;
    assign pin_a_cfg.enable = pin_a_enable;
    assign pin_a_cfg.drive_mode = pin_a_drive_mode;
    assign pin_a_cfg.polarity = pin_a_polarity;

    // Pin B settings; it floats unless selected for the interrupt.
    assign pin_b_cfg.irq = pin_b_irq_q;
    assign pin_b_cfg.enable =
        (pin_b_function_select == FS_IRQ_CODE);
    assign pin_b_cfg.drive_mode = pin_b_drive_mode;
    assign pin_b_cfg.polarity = pin_b_polarity;

    // Output stage of pin A.
    pin_driver u_pin_a (
        .clk(clk),
        .rst_n(rst_n),
        .en(en),
        .cfg(pin_a_cfg.drv),
        .pin_o(irq_pin_a_o),
        .pin_oe(irq_pin_a_oe)
    );

    // Output stage of pin B.
    pin_driver u_pin_b (
        .clk(clk),
        .rst_n(rst_n),
        .en(en),
        .cfg(pin_b_cfg.drv),
        .pin_o(irq_pin_b_o),
        .pin_oe(irq_pin_b_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign queue_flush = flush_q;

endmodule
`default_nettype wire

// ==== verif/irq_pin_chk.sv ====
// Concurrent checks on the ports of the interrupt status and pin block.
`timescale 1ns/1ps
`default_nettype none
module irq_pin_chk
    import irq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [BYTE_CNT_W-1:0] queue_byte_count,
    input wire logic queue_flush,
    input wire logic first_slot_event,
    input wire logic second_slot_event,
    input wire logic irq_pin_a_o,
    input wire logic irq_pin_a_oe,
    input wire logic irq_pin_b_o,
    input wire logic irq_pin_b_oe
);
    logic [DATA_W-1:0] cfg_q, cfg_d, msk_q, msk_d;
    logic [FS_W-1:0] fs_q, fs_d;
    logic quiet;

    ////////////////////////////////////////////////////////////////////////
    // Shadow copies of the configuration that the host has written.
    always_comb begin
        cfg_d = cfg_q;
        msk_d = msk_q;
        fs_d = fs_q;
        if (en && reg_wr && reg_addr == OFS_PIN_CFG) cfg_d = reg_wdata;
        if (en && reg_wr && reg_addr == OFS_MASK) msk_d = reg_wdata;
        if (en && reg_wr && reg_addr == OFS_PIN_B_FUNC) begin
            fs_d = reg_wdata[FS_LSB +: FS_W];
        end
        quiet = msk_q[MSK_SLOT_A_BIT] & msk_q[MSK_SLOT_B_BIT]
            & msk_q[MSK_FIFO_BIT];
    end

    // Registers the shadows with the same reset values as the block.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= PIN_CFG_RST;
            msk_q <= MASK_RST;
            fs_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            msk_q <= msk_d;
            fs_q <= fs_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_count;
        reg_rvalid && $past(en) && $past(reg_rd)
            && $past(reg_addr) == OFS_STATUS
            |-> reg_rdata[ST_CNT_LSB +: BYTE_CNT_W]
            == $past(queue_byte_count);
    endproperty
    a_count: assert property (p_count)
        else $error("byte count wrong");
    property p_flush;
        en && reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_FIFO_CLR_BIT]
            |=> queue_flush;
    endproperty
    a_flush: assert property (p_flush) else $error("no flush");
    property p_slot_b;
        en && second_slot_event ##1 en && reg_rd && reg_addr == OFS_STATUS
            |=> reg_rvalid && reg_rdata[ST_SLOT_B_BIT];
    endproperty
    a_slot_b: assert property (p_slot_b) else $error("slot b flag");
    property p_slot_a;
        en && first_slot_event ##1 en && reg_rd && reg_addr == OFS_STATUS
            |=> reg_rvalid && reg_rdata[ST_SLOT_A_BIT];
    endproperty
    a_slot_a: assert property (p_slot_a) else $error("slot a flag");
    property p_quiet;
        $past(quiet, 2) && $past(en) && $past(en, 2)
            && $past(cfg_q[PC_A_ENA_BIT])
            |-> irq_pin_a_o == $past(cfg_q[PC_A_POL_BIT])
            && irq_pin_a_oe == !$past(cfg_q[PC_A_DRIVE_BIT]);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("masked irq");
    property p_a_off;
        $past(en) && !$past(cfg_q[PC_A_ENA_BIT]) |-> !irq_pin_a_oe;
    endproperty
    a_a_off: assert property (p_a_off) else $error("pin a driven");
    property p_b_func;
        $past(en) && $past(fs_q) != FS_IRQ_CODE |-> !irq_pin_b_oe;
    endproperty
    a_b_func: assert property (p_b_func) else $error("pin b func");
    property p_b_push;
        $past(en) && $past(fs_q) == FS_IRQ_CODE
            && !$past(cfg_q[PC_B_DRIVE_BIT]) |-> irq_pin_b_oe;
    endproperty
    a_b_push: assert property (p_b_push) else $error("pin b idle");
    property p_b_open;
        $past(en) && $past(fs_q) == FS_IRQ_CODE && $past(cfg_q[PC_B_DRIVE_BIT])
            |-> irq_pin_b_oe == (irq_pin_b_o != $past(cfg_q[PC_B_POL_BIT]));
    endproperty
    a_b_open: assert property (p_b_open)
        else $error("pin b drain");
    property p_same;
        $past(en) && irq_pin_a_oe && irq_pin_b_oe
            |-> (irq_pin_a_o ^ $past(cfg_q[PC_A_POL_BIT]))
            == (irq_pin_b_o ^ $past(cfg_q[PC_B_POL_BIT]));
    endproperty
    a_same: assert property (p_same)
        else $error("pins differ");
endmodule

bind irq_status_mask_pin_logic irq_pin_chk u_irq_pin_chk (.clk(clk),
    .rst_n(rst_n), .en(en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .queue_byte_count(queue_byte_count),
    .queue_flush(queue_flush), .first_slot_event(first_slot_event),
    .second_slot_event(second_slot_event), .irq_pin_a_o(irq_pin_a_o),
    .irq_pin_a_oe(irq_pin_a_oe), .irq_pin_b_o(irq_pin_b_o),
    .irq_pin_b_oe(irq_pin_b_oe));
`default_nettype wire

// ==== verif/host_pin_model.sv ====
// Host side model that resolves the two interrupt pin wires.
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
    input wire logic a_o,
    input wire logic a_oe,
    input wire logic a_pull,
    input wire logic b_o,
    input wire logic b_oe,
    input wire logic b_pull,
    output logic a_wire,
    output logic b_wire
);
    // A released pin settles to the resistor the host fitted to it.
    always_comb begin
        a_wire = a_oe ? a_o : a_pull;
        b_wire = b_oe ? b_o : b_pull;
    end
endmodule
`default_nettype wire

// ==== verif/irq_status_mask_pin_logic_tb.sv ====
// Self-checking testbench for the interrupt status, mask and pin block.
`timescale 1ns/1ps
`default_nettype none
module irq_status_mask_pin_logic_tb
    import irq_pkg::*;
;
    localparam logic [DATA_W-1:0] PIN_TBL [4] = '{16'h0000, 16'h0004,
        16'h0307, 16'h0105};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_rvalid, queue_flush, a_o, a_oe, b_o, b_oe, a_wire, b_wire;
    logic [BYTE_CNT_W-1:0] queue_byte_count = 8'h05;
    logic first_slot_event = 1'b0;
    logic second_slot_event = 1'b0;
    logic [SPARE_EVT_W-1:0] spare_event = '0;
    logic [DATA_W-1:0] pcfg = '0;
    logic fsel = 1'b0;
    int nflush = 0;
    int n_fail = 0;
    int checks = 0;

    irq_status_mask_pin_logic u_irq_status_mask_pin_logic (.clk(clk),
        .rst_n(rst_n), .en(en), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .queue_byte_count(queue_byte_count),
        .queue_flush(queue_flush), .first_slot_event(first_slot_event),
        .second_slot_event(second_slot_event), .spare_event(spare_event),
        .irq_pin_a_o(a_o), .irq_pin_a_oe(a_oe), .irq_pin_b_o(b_o),
        .irq_pin_b_oe(b_oe));
    host_pin_model u_host_pin_model (.a_o(a_o), .a_oe(a_oe),
        .a_pull(pcfg[PC_A_POL_BIT]), .b_o(b_o), .b_oe(b_oe),
        .b_pull(pcfg[PC_B_POL_BIT]), .a_wire(a_wire), .b_wire(b_wire));

    ////////////////////////////////////////////////////////////////////////
    // Clock, and a sample queue that empties when told to.
    always #2.5 clk = ~clk;
    always @(negedge clk) begin
        if (queue_flush === 1'b1) begin
            queue_byte_count <= '0;
            nflush++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers; each starts and ends at a falling edge.
    task automatic chk(input logic [DATA_W-1:0] got,
        input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk({15'h0000, reg_rvalid}, 16'h0001);
        chk(reg_rdata, exp);
        @(negedge clk);
    endtask
    task automatic pins(input logic irq);
        logic ea, eb;
        repeat (3) @(negedge clk);
        ea = pcfg[PC_A_ENA_BIT] & (~pcfg[PC_A_DRIVE_BIT] | irq);
        eb = fsel & (~pcfg[PC_B_DRIVE_BIT] | irq);
        chk({14'h0, a_oe, a_wire},
            {14'h0, ea, (ea & irq) ^ pcfg[PC_A_POL_BIT]});
        chk({14'h0, b_oe, b_wire},
            {14'h0, eb, (eb & irq) ^ pcfg[PC_B_POL_BIT]});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset;
        rd(OFS_MASK, MASK_RST);
        rd(OFS_PIN_CFG, PIN_CFG_RST);
        rd(OFS_STATUS, 16'h0500);
        rd(8'h03, 16'h0000);
    endtask
    task automatic t_flags;
        queue_byte_count = 8'h2A;
        en = 1'b0;
        first_slot_event = 1'b1;
        @(negedge clk);
        en = 1'b1;
        first_slot_event = 1'b0;
        second_slot_event = 1'b1;
        @(negedge clk);
        second_slot_event = 1'b0;
        rd(OFS_STATUS, 16'h2A40);
        first_slot_event = 1'b1;
        @(negedge clk);
        first_slot_event = 1'b0;
        rd(OFS_STATUS, 16'h2A60);
        wr(OFS_STATUS, 16'h0000);
        rd(OFS_STATUS, 16'h2A60);
        wr(OFS_STATUS, 16'h0020);
        rd(OFS_STATUS, 16'h2A40);
        wr(OFS_STATUS, 16'h0040);
        rd(OFS_STATUS, 16'h2A00);
        spare_event = 6'h3F;
        @(negedge clk);
        spare_event = 6'h00;
        rd(OFS_STATUS, 16'h2A9F);
        wr(OFS_STATUS, 16'h001E);
        rd(OFS_STATUS, 16'h2A9F);
        wr(OFS_STATUS, 16'h0080);
        rd(OFS_STATUS, 16'h2A1F);
        wr(OFS_STATUS, 16'h001F);
        rd(OFS_STATUS, 16'h2A00);
    endtask
    task automatic t_flush;
        wr(OFS_STATUS, 16'h7F00);
        chk(16'(nflush), 16'h0000);
        wr(OFS_STATUS, 16'h8000);
        chk(16'(nflush), 16'h0001);
        rd(OFS_STATUS, 16'h0000);
    endtask
    task automatic t_pins;
        for (int i = 0; i < 4; i++) begin
            pcfg = PIN_TBL[i];
            fsel = (i != 0);
            wr(OFS_PIN_CFG, pcfg);
            wr(OFS_PIN_B_FUNC, {3'h0, fsel ? FS_IRQ_CODE : 5'h00, 8'h00});
            wr(OFS_MASK, MASK_RST);
            first_slot_event = 1'b1;
            @(negedge clk);
            first_slot_event = 1'b0;
            pins(1'b0);
            wr(OFS_MASK, 16'h01DF);
            pins(1'b1);
            rd(OFS_STATUS, 16'h0020);
            wr(OFS_STATUS, 16'h0020);
            pins(1'b0);
        end
    endtask
    task automatic t_fifo;
        wr(OFS_THRESH, 16'h0300);
        wr(OFS_MASK, 16'h00FF);
        for (int b = 6; b <= 9; b++) begin
            queue_byte_count = 8'(b);
            pins((8'(b) >> 1) > 8'h03);
        end
        queue_byte_count = 8'h07;
        pins(1'b0);
        rd(OFS_STATUS, 16'h0700);
    endtask

    task automatic summarize;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence after an eight cycle reset.
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset;
        t_flags;
        t_flush;
        t_pins;
        t_fifo;
        summarize;
    end

    // Cuts a hung run short.
    initial begin
        #100000;
        n_fail++;
        $display("CHECK FAILED t=%0t timeout", $time);
        summarize;
    end
endmodule
`default_nettype wire
